// ==== pkg/dlc_pkg.sv ====
// constants and types shared by the display-list coprocessor sequencer
// assumes a 16-bit word bus with byte offsets into the register space
`default_nettype none

package dlc_pkg;

	// register byte offsets inside the custom register space
	localparam logic [8:0] DLC_OFF_CONTROL    = 9'h01c;
	localparam logic [8:0] DLC_OFF_STATUS     = 9'h01e;
	localparam logic [8:0] DLC_OFF_PTR1_HIGH  = 9'h080;
	localparam logic [8:0] DLC_OFF_PTR1_LOW   = 9'h082;
	localparam logic [8:0] DLC_OFF_PTR2_HIGH  = 9'h084;
	localparam logic [8:0] DLC_OFF_PTR2_LOW   = 9'h086;
	localparam logic [8:0] DLC_OFF_STROBE1    = 9'h088;
	localparam logic [8:0] DLC_OFF_STROBE2    = 9'h08a;

	// register-number protection ranges
	localparam logic [7:0] DLC_REGNUM_DANGER_LO = 8'h10;
	localparam logic [7:0] DLC_REGNUM_SAFE_LO   = 8'h20;

	// field positions
	localparam int DLC_CTRL_DANGER_BIT = 1;
	localparam int DLC_STAT_WAIT_BIT   = 0;
	localparam int DLC_STAT_RUN_BIT    = 1;
	localparam int DLC_PTR_HIGH_BITS   = 3;
	localparam int DLC_ADDR_W          = 19;

	// reset values
	localparam logic       DLC_DANGER_RESET = 1'b0;
	localparam logic [18:0] DLC_PTR_RESET   = 19'h00000;

	// program counter advance per fetched word, in bytes
	localparam logic [18:0] DLC_PC_STEP = 19'h00002;

	typedef enum logic [2:0] {
		DLC_IDLE,
		DLC_FETCH1,
		DLC_FETCH2,
		DLC_EXEC,
		DLC_WAIT
	} dlc_state_e;

endpackage

`default_nettype wire

// ==== rtl/dlc_beam_cmp.sv ====
// masked greater-or-equal compare of beam counters against a wait position
// assumes beam counters come from logic on the same clock
`default_nettype none
`timescale 1ns/100ps

module dlc_beam_cmp
	import dlc_pkg::*;
(
	// beam counters
	input  wire logic [7:0]  beam_vert,
	input  wire logic [7:0]  beam_horiz,
	// instruction words
	input  wire logic [15:0] instr_word_first,
	input  wire logic [15:0] instr_word_second,
	// result
	output logic             reached
);

	logic [6:0]  vert_compare_enables;
	logic [6:0]  horiz_compare_enables;
	logic [7:0]  wait_vert_pos;
	logic [6:0]  wait_horiz_pos;
	logic [14:0] beam_masked;
	logic [14:0] target_masked;

	// word layout: position in the first, enables in the second
	assign wait_vert_pos         = instr_word_first[15:8];
	assign wait_horiz_pos        = instr_word_first[7:1];
	assign vert_compare_enables  = instr_word_second[14:8];
	assign horiz_compare_enables = instr_word_second[7:1];

	// vertical msb has no enable, so it always takes part
	// horizontal lsb is dropped: only 128 comparable slots
	assign beam_masked = {beam_vert[7], beam_vert[6:0] & vert_compare_enables,
		beam_horiz[7:1] & horiz_compare_enables};
	assign target_masked = {wait_vert_pos[7], wait_vert_pos[6:0] & vert_compare_enables,
		wait_horiz_pos & horiz_compare_enables};

	// vertical above horizontal, so order follows beam travel
	assign reached = beam_masked >= target_masked;

endmodule // dlc_beam_cmp

`default_nettype wire

// ==== rtl/dlc_dest_gate.sv ====
// decides whether a register-write instruction may reach its destination
// assumes the register number is the byte offset divided by two
`default_nettype none
`timescale 1ns/100ps

module dlc_dest_gate
	import dlc_pkg::*;
(
	// destination
	input  wire logic [7:0] reg_num,
	// protection control
	input  wire logic       danger_write_enable,
	// result
	output logic            allowed
);

	always_comb begin
		if (reg_num >= DLC_REGNUM_SAFE_LO) begin
			allowed = 1'b1;
		end else if (reg_num >= DLC_REGNUM_DANGER_LO) begin
			allowed = danger_write_enable;
		end else begin
			allowed = 1'b0;
		end
	end

endmodule // dlc_dest_gate

`default_nettype wire

// ==== rtl/dlc_sequencer.sv ====
// display-list coprocessor sequencer: fetch, register writes, beam waits
// assumes host writes, fetch port, beam counters all run on clk
//
// Overview of operation
// - vertical blank reloads pc from first pointer
// - every field restarts at the first pointer
// - strobe write reloads pc, data ignored
// - two strobes pair with two pointers
// - own writes reach pointers and strobes
// - register numbers 20 to ff always written
// - register numbers 00 to 0f never written
// - control holds only danger enable, bit 1
// - numbers 10 to 1f need danger enable
// - danger enable clears on reset
// - wait ends when beam at or past position
// - after wait, writes run back to back
// - wait ffff,fffe never ends before restart while horizontal stays below fe
// - first word destination, second word value
// - zero enable bits make bits don't-care
// - compare order is vertical then horizontal
// - wait word field layout
// - pc advances after every fetched word
// - pointer is 3 high bits plus low word
// - horizontal lsb left out of compare
`default_nettype none
`timescale 1ns/100ps

module dlc_sequencer
	import dlc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// host register access
	input  wire logic        host_wr_en,
	input  wire logic [8:0]  host_wr_addr,
	input  wire logic [15:0] host_wr_data,
	input  wire logic        host_rd_en,
	input  wire logic [8:0]  host_rd_addr,
	output logic [15:0]      host_rd_data,
	output logic             host_rd_valid,
	// instruction fetch
	input  wire logic        fetch_enable,
	output logic             fetch_req,
	output logic [18:0]      fetch_addr,
	input  wire logic        fetch_ack,
	input  wire logic [15:0] fetch_data,
	// video timing
	input  wire logic [8:0]  beam_vert,
	input  wire logic [7:0]  beam_horiz,
	input  wire logic        vblank_start,
	// register writes out
	output logic             reg_wr_strobe,
	output logic [8:0]       reg_wr_addr,
	output logic [15:0]      reg_wr_data
);

	typedef struct packed {
		dlc_state_e  st;
		logic [18:0] pc;
		logic [18:0] ptr1;
		logic [18:0] ptr2;
		logic        danger;
		logic [15:0] ir1;
		logic [15:0] ir2;
		logic        fetch_req;
		logic [18:0] fetch_addr;
		logic        wr_stb;
		logic [8:0]  wr_addr;
		logic [15:0] wr_data;
		logic [15:0] rd_data;
		logic        rd_valid;
	} dlc_regs_s;

	dlc_regs_s s_reg;
	dlc_regs_s s_next;

	logic       reached;
	logic       allowed;
	logic       mv;
	logic       mv_ok;
	logic [8:0] mv_addr;
	logic       strobe1;
	logic       strobe2;
	logic       restart;
	logic       host_ptr;
	logic       mv_internal;

	dlc_beam_cmp u_cmp (
		.beam_vert         (beam_vert[7:0]),
		.beam_horiz        (beam_horiz),
		.instr_word_first  (s_reg.ir1),
		.instr_word_second (s_reg.ir2),
		.reached           (reached)
	);

	dlc_dest_gate u_gate (
		.reg_num             (s_reg.ir1[8:1]),
		.danger_write_enable (s_reg.danger),
		.allowed             (allowed)
	);

	// a write is any instruction whose first word has bit 0 clear
	assign mv      = (s_reg.st == DLC_EXEC) && !s_reg.ir1[0];
	assign mv_ok   = mv && allowed;
	assign mv_addr = {s_reg.ir1[8:1], 1'b0};

	// own writes may hit the jump strobes to make indirect jumps
	assign strobe1 = (host_wr_en && host_wr_addr == DLC_OFF_STROBE1)
		|| (mv_ok && mv_addr == DLC_OFF_STROBE1);
	assign strobe2 = (host_wr_en && host_wr_addr == DLC_OFF_STROBE2)
		|| (mv_ok && mv_addr == DLC_OFF_STROBE2);
	assign restart = vblank_start || strobe1 || strobe2;

	assign host_ptr = host_wr_en && host_wr_addr[8:3] == DLC_OFF_PTR1_HIGH[8:3];
	assign mv_internal = mv_addr[8:4] == DLC_OFF_PTR1_HIGH[8:4]
		&& mv_addr <= DLC_OFF_STROBE2;

	function automatic logic [18:0] ptr_write(input logic [18:0] cur,
			input logic low_half, input logic [15:0] d);
		logic [18:0] r;
		r = cur;
		if (low_half) begin
			r[15:0] = {d[15:1], 1'b0};
		end else begin
			r[18:16] = d[DLC_PTR_HIGH_BITS-1:0];
		end
		return r;
	endfunction

	always_comb begin
		s_next = s_reg;
		s_next.wr_stb   = 1'b0;
		s_next.rd_valid = 1'b0;

		case (s_reg.st)
			DLC_IDLE: begin
				// host is expected to have set a pointer and strobed first
				if (fetch_enable) begin
					s_next.st = DLC_FETCH1;
				end
			end
			DLC_FETCH1: begin
				if (s_reg.fetch_req) begin
					if (fetch_ack) begin
						s_next.ir1       = fetch_data;
						s_next.pc        = s_reg.pc + DLC_PC_STEP;
						s_next.fetch_req = 1'b0;
						s_next.st        = DLC_FETCH2;
					end
				end else if (fetch_enable) begin
					s_next.fetch_req  = 1'b1;
					s_next.fetch_addr = s_reg.pc;
				end else begin
					s_next.st = DLC_IDLE;
				end
			end
			DLC_FETCH2: begin
				// once the first word is in, the pair is completed even if fetch_enable drops; only a restart abandons it
				if (s_reg.fetch_req) begin
					if (fetch_ack) begin
						s_next.ir2       = fetch_data;
						s_next.pc        = s_reg.pc + DLC_PC_STEP;
						s_next.fetch_req = 1'b0;
						s_next.st        = DLC_EXEC;
					end
				end else begin
					s_next.fetch_req  = 1'b1;
					s_next.fetch_addr = s_reg.pc;
				end
			end
			DLC_EXEC: begin
				if (!s_reg.ir1[0]) begin
					if (mv_ok && !mv_internal) begin
						s_next.wr_stb  = 1'b1;
						s_next.wr_addr = mv_addr;
						s_next.wr_data = s_reg.ir2;
					end
					s_next.st = DLC_FETCH1;
				end else if (!s_reg.ir2[0]) begin
					s_next.st = DLC_WAIT;
				end else begin
					// skip is treated as a no-op
					s_next.st = DLC_FETCH1;
				end
			end
			DLC_WAIT: begin
				// an unreachable position just holds here until a restart
				if (reached) begin
					s_next.st = DLC_FETCH1;
				end
			end
			default: begin
				s_next.st = DLC_IDLE;
			end
		endcase

		// own pointer writes first, so a host write in the same cycle wins
		if (mv_ok && mv_internal && mv_addr[2] == 1'b0) begin
			if (mv_addr[3:2] == DLC_OFF_PTR1_HIGH[3:2]) begin
				s_next.ptr1 = ptr_write(s_reg.ptr1, mv_addr[1], s_reg.ir2);
			end
		end
		if (mv_ok && mv_internal) begin
			if (mv_addr[2:1] == 2'b10 && mv_addr[3] == 1'b0) begin
				s_next.ptr2 = ptr_write(s_reg.ptr2, 1'b0, s_reg.ir2);
			end else if (mv_addr[2:1] == 2'b11 && mv_addr[3] == 1'b0) begin
				s_next.ptr2 = ptr_write(s_reg.ptr2, 1'b1, s_reg.ir2);
			end else if (mv_addr[2:1] == 2'b01 && mv_addr[3] == 1'b0) begin
				s_next.ptr1 = ptr_write(s_reg.ptr1, 1'b1, s_reg.ir2);
			end
		end
		if (host_ptr) begin
			if (host_wr_addr[2] == 1'b0) begin
				s_next.ptr1 = ptr_write(s_reg.ptr1, host_wr_addr[1], host_wr_data);
			end else begin
				s_next.ptr2 = ptr_write(s_reg.ptr2, host_wr_addr[1], host_wr_data);
			end
		end

		// only the host reaches control, as own writes there are gated off
		if (host_wr_en && host_wr_addr == DLC_OFF_CONTROL) begin
			s_next.danger = host_wr_data[DLC_CTRL_DANGER_BIT];
		end

		// restarts override whatever is executing; vertical blank wins
		if (restart) begin
			s_next.fetch_req = 1'b0;
			s_next.st        = DLC_FETCH1;
			if (vblank_start) begin
				s_next.pc = s_reg.ptr1;
			end else if (strobe1) begin
				s_next.pc = s_reg.ptr1;
			end else begin
				s_next.pc = s_reg.ptr2;
			end
		end

		if (host_rd_en) begin
			s_next.rd_valid = 1'b1;
			s_next.rd_data  = 16'h0000;
			if (host_rd_addr == DLC_OFF_CONTROL) begin
				s_next.rd_data[DLC_CTRL_DANGER_BIT] = s_reg.danger;
			end else if (host_rd_addr == DLC_OFF_STATUS) begin
				s_next.rd_data[DLC_STAT_WAIT_BIT] = s_reg.st == DLC_WAIT;
				s_next.rd_data[DLC_STAT_RUN_BIT]  = s_reg.st != DLC_IDLE;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_reg            <= '0;
			s_reg.st         <= DLC_IDLE;
			s_reg.ptr1       <= DLC_PTR_RESET;
			s_reg.ptr2       <= DLC_PTR_RESET;
			s_reg.danger     <= DLC_DANGER_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign host_rd_data  = s_reg.rd_data;
	assign host_rd_valid = s_reg.rd_valid;
	assign fetch_req     = s_reg.fetch_req;
	assign fetch_addr    = s_reg.fetch_addr;
	assign reg_wr_strobe = s_reg.wr_stb;
	assign reg_wr_addr   = s_reg.wr_addr;
	assign reg_wr_data   = s_reg.wr_data;

	property p_vblank_reload;
		@(posedge clk) disable iff (!resetn)
		vblank_start |=> (s_reg.pc == $past(s_reg.ptr1)) && (s_reg.st == DLC_FETCH1);
	endproperty
	a_vblank_reload: assert property (p_vblank_reload)
		else $error("vertical blank did not reload pc from first pointer");

	property p_strobe2;
		@(posedge clk) disable iff (!resetn)
		(host_wr_en && host_wr_addr == DLC_OFF_STROBE2 && !vblank_start && !strobe1)
			|=> s_reg.pc == $past(s_reg.ptr2) && !fetch_req;
	endproperty
	a_strobe2: assert property (p_strobe2)
		else $error("second strobe did not load pc from second pointer");

	property p_low_never;
		@(posedge clk) disable iff (!resetn)
		reg_wr_strobe |-> reg_wr_addr[8:1] >= DLC_REGNUM_DANGER_LO;
	endproperty
	a_low_never: assert property (p_low_never)
		else $error("write issued to never-writable register");

	property p_danger;
		@(posedge clk) disable iff (!resetn)
		(reg_wr_strobe && reg_wr_addr[8:1] < DLC_REGNUM_SAFE_LO) |-> $past(s_reg.danger);
	endproperty
	a_danger: assert property (p_danger)
		else $error("protected register written without danger enable");

	property p_always;
		@(posedge clk) disable iff (!resetn)
		(mv && s_reg.ir1[8:1] >= DLC_REGNUM_SAFE_LO && !mv_internal)
			|=> reg_wr_strobe && reg_wr_data == $past(s_reg.ir2)
			&& reg_wr_addr == {$past(s_reg.ir1[8:1]), 1'b0};
	endproperty
	a_always: assert property (p_always)
		else $error("allowed register write not carried out");

	property p_wait_done;
		@(posedge clk) disable iff (!resetn)
		(s_reg.st == DLC_WAIT && reached && !restart) |=> s_reg.st == DLC_FETCH1;
	endproperty
	a_wait_done: assert property (p_wait_done)
		else $error("wait did not end with beam at or past target");

	property p_never;
		@(posedge clk) disable iff (!resetn)
		(s_reg.st == DLC_WAIT && s_reg.ir1 == 16'hffff && s_reg.ir2 == 16'hfffe
			&& beam_horiz <= 8'he2 && !restart) |=> s_reg.st == DLC_WAIT;
	endproperty
	a_never: assert property (p_never)
		else $error("end-of-list wait finished before restart");

	property p_pc_inc;
		@(posedge clk) disable iff (!resetn)
		(s_reg.fetch_req && fetch_ack && !restart)
			|=> s_reg.pc == $past(s_reg.pc) + DLC_PC_STEP;
	endproperty
	a_pc_inc: assert property (p_pc_inc)
		else $error("pc did not advance after a fetch");

	property p_mask_vert;
		@(posedge clk) disable iff (!resetn)
		(s_reg.ir1[15:1] == 15'h4b00 && s_reg.ir2[14:1] == 14'h3f80)
			|-> reached == (beam_vert[7:0] >= 8'h96);
	endproperty
	a_mask_vert: assert property (p_mask_vert)
		else $error("line-only wait compared horizontal bits");

endmodule // dlc_sequencer

`default_nettype wire

// ==== dv/dlc_mem_model.sv ====
// behavioural instruction memory on the sequencer's fetch port
// assumes fetch_req and fetch_addr come from the sequencer on clk
`default_nettype none
`timescale 1ns/100ps

module dlc_mem_model (
	// clock
	input  wire logic        clk,
	// fetch port
	input  wire logic        fetch_req,
	input  wire logic [18:0] fetch_addr,
	output logic             fetch_ack,
	output logic [15:0]      fetch_data,
	// extra answer delay in cycles
	input  wire logic [1:0]  delay
);
	logic [15:0] words [0:127];
	logic [1:0]  wait_cnt;

	// words are filled by the bench alone, so no start-up race over them
	// no reset here: the first edge settles ack while the sequencer is held
	// one ack per request, never in the cycle the request rises
	always @(posedge clk) begin
		if (fetch_req && !fetch_ack && wait_cnt >= delay) begin
			fetch_ack  <= 1'b1;
			fetch_data <= words[fetch_addr[7:1]];
			wait_cnt   <= 2'h0;
		end else begin
			fetch_ack  <= 1'b0;
			// junk outside an answer, so a stale word is never reused
			fetch_data <= ~fetch_data;
			wait_cnt   <= (fetch_req && !fetch_ack) ? wait_cnt + 2'h1 : 2'h0;
		end
	end
endmodule // dlc_mem_model

`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench: host register calls and instruction lists in memory
// assumes dlc_pkg compiled first and the memory model beside the sequencer
`default_nettype none
`timescale 1ns/100ps

module tb;
	import dlc_pkg::*;

	logic        clk, resetn, host_wr_en, host_rd_en, host_rd_valid;
	logic [8:0]  host_wr_addr, host_rd_addr, beam_vert, reg_wr_addr;
	logic [15:0] host_wr_data, host_rd_data, fetch_data, reg_wr_data, rd_val;
	logic        fetch_enable, fetch_req, fetch_ack, vblank_start, reg_wr_strobe;
	logic [18:0] fetch_addr;
	logic [7:0]  beam_horiz, lp;
	logic [1:0]  delay;
	logic [24:0] wq[$];
	logic [18:0] fq[$];
	int          errors, tests_run;

	dlc_sequencer dut (.clk(clk), .resetn(resetn), .host_wr_en(host_wr_en),
		.host_wr_addr(host_wr_addr), .host_wr_data(host_wr_data), .host_rd_en(host_rd_en),
		.host_rd_addr(host_rd_addr), .host_rd_data(host_rd_data),
		.host_rd_valid(host_rd_valid), .fetch_enable(fetch_enable), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
		.beam_vert(beam_vert), .beam_horiz(beam_horiz), .vblank_start(vblank_start),
		.reg_wr_strobe(reg_wr_strobe), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));

	dlc_mem_model mem (.clk(clk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.fetch_ack(fetch_ack), .fetch_data(fetch_data), .delay(delay));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// record every register write out and every accepted fetch address
	always @(posedge clk) begin
		if (reg_wr_strobe === 1'b1) wq.push_back({reg_wr_addr, reg_wr_data});
		if (fetch_req === 1'b1 && fetch_ack === 1'b1) fq.push_back(fetch_addr);
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		if (errors == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		host_wr_en   = 1'b1;
		host_wr_addr = a;
		host_wr_data = d;
		@(posedge clk);
		#1;
		host_wr_en   = 1'b0;
	endtask

	task automatic rd(input logic [8:0] a);
		@(posedge clk);
		#1;
		host_rd_en   = 1'b1;
		host_rd_addr = a;
		@(posedge clk);
		#1;
		host_rd_en   = 1'b0;
		rd_val       = host_rd_data;
		check(host_rd_valid, 1'b1);
	endtask

	// one two-word instruction at the load pointer
	task automatic putw(input logic [15:0] w1, input logic [15:0] w2);
		mem.words[lp[7:1]]        = w1;
		mem.words[lp[7:1] + 7'h1] = w2;
		lp = lp + 8'h04;
	endtask

	// wait for n writes out, then make sure no further one follows
	task automatic settle(input int n);
		int i;
		i = 0;
		while (wq.size() < n && i < 400) begin
			@(posedge clk);
			i++;
		end
		repeat (40) @(posedge clk);
		#1;
		check(wq.size(), n);
	endtask

	task automatic expw(input logic [8:0] a, input logic [15:0] d);
		logic [24:0] got;
		got = (wq.size() > 0) ? wq.pop_front() : 25'h1ffffff;
		check(got, {a, d});
	endtask

	initial begin
		#200000;
		errors++;
		final_report();
	end

	initial begin
		resetn = 1'b0;
		{host_wr_en, host_rd_en, fetch_enable, vblank_start} = 4'h0;
		host_wr_addr = 9'h000;
		host_rd_addr = 9'h000;
		host_wr_data = 16'h0000;
		beam_vert    = 9'h095;
		beam_horiz   = 8'h00;
		delay        = 2'h0;
		errors       = 0;
		tests_run    = 0;
		for (int i = 0; i < 128; i++) mem.words[i] = 16'hffff;
		lp = 8'h00;
		putw(16'h0010, 16'h1111);
		putw(16'h0020, 16'h2222);
		putw(16'h0040, 16'h3333);
		putw(16'h01fe, 16'h4444);
		putw(16'h9601, 16'hff00);
		putw(16'h0180, 16'h5555);
		putw(16'h1041, 16'hfffe);
		putw(16'h0182, 16'h6666);
		putw(16'h0084, 16'h0000);
		putw(16'h0086, 16'h0060);
		putw(16'h008a, 16'h0000);
		putw(16'hffff, 16'hfffe);
		lp = 8'h60;
		putw(16'h0184, 16'h7777);
		putw(16'hffff, 16'hfffe);
		putw(16'h018a, 16'haaaa);
		lp = 8'h80;
		putw(16'h2041, 16'hfffe);
		putw(16'h0186, 16'h8888);
		putw(16'h2241, 16'hfffe);
		putw(16'h0188, 16'h9999);
		putw(16'hffff, 16'hfffe);
		repeat (3) @(posedge clk);
		#1;
		resetn = 1'b1;
		rd(DLC_OFF_CONTROL);
		check(rd_val, 16'h0000);
		wr(DLC_OFF_CONTROL, 16'hffff);
		rd(DLC_OFF_CONTROL);
		check(rd_val, 16'h0002);
		wr(DLC_OFF_CONTROL, 16'h0000);
		wr(DLC_OFF_PTR1_HIGH, 16'h0000);
		wr(DLC_OFF_PTR1_LOW, 16'h0000);
		wr(DLC_OFF_STROBE1, 16'hffff);
		fetch_enable = 1'b1;
		settle(2);
		expw(9'h040, 16'h3333);
		expw(9'h1fe, 16'h4444);
		rd(DLC_OFF_STATUS);
		check(rd_val, 16'h0003);
		beam_vert = 9'h096;
		settle(3);
		expw(9'h180, 16'h5555);
		expw(9'h182, 16'h6666);
		expw(9'h184, 16'h7777);
		for (int i = 0; i < 6; i++) check(fq[i], 2 * i);
		beam_vert  = 9'h0ff;
		beam_horiz = 8'he2;
		settle(0);
		fq.delete();
		delay = 2'h2;
		@(posedge clk);
		#1;
		vblank_start = 1'b1;
		@(posedge clk);
		#1;
		vblank_start = 1'b0;
		settle(5);
		check(fq[0], 19'h00000);
		expw(9'h040, 16'h3333);
		wq.delete();
		beam_vert  = 9'h023;
		beam_horiz = 8'h00;
		wr(DLC_OFF_CONTROL, 16'h0002);
		wr(DLC_OFF_STROBE1, 16'h0000);
		settle(3);
		expw(9'h020, 16'h2222);
		wq.delete();
		wr(DLC_OFF_PTR1_LOW, 16'h0080);
		beam_vert  = 9'h020;
		beam_horiz = 8'h3f;
		wr(DLC_OFF_STROBE1, 16'h0000);
		settle(0);
		beam_horiz = 8'h40;
		settle(1);
		expw(9'h186, 16'h8888);
		beam_vert  = 9'h023;
		beam_horiz = 8'h00;
		settle(1);
		expw(9'h188, 16'h9999);
		// host-loaded second pointer, odd low word must lose its bit 0
		wr(DLC_OFF_PTR2_HIGH, 16'h0000);
		wr(DLC_OFF_PTR2_LOW, 16'h0069);
		wr(DLC_OFF_STROBE2, 16'h1234);
		// filler words decode as skips, which run on as no-ops
		settle(3);
		expw(9'h18a, 16'haaaa);
		expw(9'h186, 16'h8888);
		expw(9'h188, 16'h9999);
		final_report();
	end
endmodule // tb

`default_nettype wire
